// [bench/cpf_flow_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module cpf_flow_chk import cpf_pkg::*; (
  input wire logic          core_clk,
  input wire logic          nrst,
  input wire logic          ser_tx,
  input wire cpf_card_req_t card_req,
  input wire cpf_byte_t     card_tx,
  input wire cpf_card_rsp_t card_rsp,
  input wire logic          card_present,
  input wire cpf_phase_t    phase
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_go_pulse; card_req.go |=> !card_req.go; endproperty
  a_go_pulse: assert property (p_go_pulse)
    else $error("go pulse too long");
  property p_op_hold; !card_req.go |-> $stable(card_req.op); endproperty
  a_op_hold: assert property (p_op_hold)
    else $error("op moved without go");
  property p_poll_only;
    card_req.go && phase == PH_POLL |-> card_req.op == OP_POLL;
  endproperty
  a_poll_only: assert property (p_poll_only)
    else $error("card op out of order");
  property p_act_phase;
    card_req.go && card_req.op == OP_ACT |-> phase == PH_ACT;
  endproperty
  a_act_phase: assert property (p_act_phase)
    else $error("activation outside its phase");
  property p_xch_phase;
    card_req.go && card_req.op inside {OP_XCH, OP_CSEND, OP_CRECV}
      |-> phase == PH_XACT;
  endproperty
  a_xch_phase: assert property (p_xch_phase)
    else $error("exchange outside its phase");
  property p_fwd_phase; card_tx.valid |-> phase == PH_XACT; endproperty
  a_fwd_phase: assert property (p_fwd_phase)
    else $error("apdu byte forwarded outside transaction");
  property p_to_xact;
    $changed(phase) && phase == PH_XACT |-> $past(phase) == PH_ACT
      && $past(card_rsp.done) && $past(card_rsp.res) == RES_OK;
  endproperty
  a_to_xact: assert property (p_to_xact)
    else $error("bad entry to transaction");
  property p_to_poll;
    $changed(phase) && phase == PH_POLL
      |-> $past(card_rsp.done) || !$past(card_present);
  endproperty
  a_to_poll: assert property (p_to_poll)
    else $error("polling reentered early");
  property p_start_bit; $fell(ser_tx) |-> !ser_tx [*8]; endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("serial low too short");
  c_more: cover property (card_rsp.done && card_rsp.res == RES_MORE);
  c_csend: cover property (card_req.go && card_req.op == OP_CSEND);
  c_poll: cover property ($changed(phase) && phase == PH_POLL);
endmodule
`default_nettype wire

// [bench/cpf_flow_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module cpf_flow_tb_top import cpf_pkg::*; ;
  localparam int unsigned D = 16;
  // Arbitrary identification text
  localparam logic [8*ID_LEN-1:0] ID = "TB ID 01";
  logic          core_clk, nrst, h_tx, d_tx, card_present;
  cpf_card_req_t card_req;
  cpf_byte_t     card_tx, card_rx;
  cpf_card_rsp_t card_rsp;
  cpf_phase_t    phase;
  cpf_op_t       go_op;
  logic [7:0]    fwd_q[$];
  logic [7:0]    b;
  int            miscompares, checks, seed, go_n, i;

  cpf_flow #(.DIV(D), .ID_TEXT(ID)) DUT (
    .core_clk(core_clk), .nrst(nrst), .ser_rx(h_tx), .ser_tx(d_tx),
    .card_req(card_req), .card_tx(card_tx), .card_rx(card_rx),
    .card_rsp(card_rsp), .card_present(card_present), .phase(phase));
  cpf_host #(.DIV(D)) host (
    .core_clk(core_clk), .line_out(h_tx), .line_in(d_tx));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Falling edge sees each one-cycle pulse exactly once
  always @(negedge core_clk) begin
    if (card_tx.valid === 1'b1) fwd_q.push_back(card_tx.data);
    if (card_req.go === 1'b1) begin
      go_n++;
      go_op = card_req.op;
    end
  end

  task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task get(output logic [7:0] v);
    for (int k = 0; k < 40000 && host.rxq.size() == 0; k++)
      @(negedge core_clk);
    if (host.rxq.size() == 0) begin
      miscompares++;
      stop_test;
    end else begin
      v = host.rxq.pop_front();
    end
  endtask

  task boot;
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    cmp("reset phase", 8'(PH_POLL), 8'(phase));
    nrst = 1'b1;
    for (int k = 0; k < ID_LEN; k++) begin
      get(b);
      cmp("banner", ID[8*(ID_LEN-1-k) +: 8], b);
    end
    $display("test boot done");
  endtask

  // Automatic so the APDU and answer queues start empty on every call
  task automatic run(input string nm, input logic [7:0] sub, input cpf_op_t op,
           input int n, input int m, input cpf_res_t res, input bit ok,
           input cpf_phase_t ph);
    logic [7:0] ap[$];
    logic [7:0] rd[$];
    logic [7:0] st;
    int         g0;
    g0 = go_n;
    fwd_q.delete();
    host.send(CMD_LEAD);
    host.send(sub);
    if (sub == SUB_XCH || sub == SUB_CSEND) begin
      host.send(8'(n));
      repeat (n) begin
        ap.push_back(8'($random(seed)));
        host.send(ap[$]);
      end
    end
    if (ok) begin
      for (int k = 0; k < 40000 && go_n == g0; k++) @(negedge core_clk);
      if (go_n == g0) begin
        miscompares++;
        stop_test;
      end else begin
        cmp("op", 8'(op), 8'(go_op));
        repeat (m) begin
          rd.push_back(8'($random(seed)));
          card_rx <= '{1'b1, rd[$]};
          @(negedge core_clk);
          card_rx <= '0;
          @(negedge core_clk);
        end
        card_rsp <= '{1'b1, res};
        @(negedge core_clk);
        card_rsp <= '0;
        if (op == OP_REL) begin
          // Card still in field: reply must stay back
          repeat (300) @(negedge core_clk);
          cmp("early reply", 8'h00, 8'(host.rxq.size()));
          card_present <= 1'b0;
        end
      end
    end
    st = (!ok || res == RES_FAIL) ? STAT_FAIL
       : (res == RES_MORE) ? STAT_MORE : STAT_OK;
    get(b);
    cmp("status", st, b);
    if (sub != SUB_POLL && sub != SUB_ACT && sub != SUB_REL) begin
      get(b);
      cmp("length", 8'(rd.size()), b);
      foreach (rd[k]) begin
        get(b);
        cmp("data", rd[k], b);
      end
    end
    repeat (200) @(negedge core_clk);
    cmp("extra bytes", 8'h00, 8'(host.rxq.size()));
    cmp("go count", 8'(ok), 8'(go_n - g0));
    cmp("fwd count", 8'(ok ? ap.size() : 0), 8'(fwd_q.size()));
    foreach (fwd_q[k]) cmp("fwd byte", ap[k], fwd_q[k]);
    cmp("phase", 8'(ph), 8'(phase));
    $display("test %s done", nm);
  endtask

  initial begin
    seed = 32;
    miscompares = 0;
    checks = 0;
    go_n = 0;
    card_present = 1'b1;
    card_rx = '0;
    card_rsp = '0;
    boot;
    run("xch early", SUB_XCH, OP_XCH, 1, 0, RES_OK, 0, PH_POLL);
    run("act early", SUB_ACT, OP_ACT, 0, 0, RES_OK, 0, PH_POLL);
    run("poll miss", SUB_POLL, OP_POLL, 0, 0, RES_FAIL, 1, PH_POLL);
    run("poll hit", SUB_POLL, OP_POLL, 0, 0, RES_OK, 1, PH_ACT);
    boot;
    run("poll hit", SUB_POLL, OP_POLL, 0, 0, RES_OK, 1, PH_ACT);
    run("activate", SUB_ACT, OP_ACT, 0, 0, RES_OK, 1, PH_XACT);
    for (i = 0; i < 3; i++)
      run("csend", SUB_CSEND, OP_CSEND, 3*i+1, 0, RES_OK, 1, PH_XACT);
    run("exchange", SUB_XCH, OP_XCH, 3, 2, RES_MORE, 1, PH_XACT);
    run("crecv", SUB_CRECV, OP_CRECV, 0, 3, RES_OK, 1, PH_XACT);
    run("release", SUB_REL, OP_REL, 0, 0, RES_OK, 1, PH_POLL);
    stop_test;
  end
endmodule

bind cpf_flow cpf_flow_chk u_chk (
  .core_clk(core_clk), .nrst(nrst), .ser_tx(ser_tx),
  .card_req(card_req), .card_tx(card_tx), .card_rsp(card_rsp),
  .card_present(card_present), .phase(phase));
`default_nettype wire

// [bench/cpf_host.sv]
`timescale 1ns/1ns
`default_nettype none
module cpf_host #(
  parameter int DIV = 16
) (
  input  wire logic core_clk,
  output logic      line_out,
  input  wire logic line_in
);
  logic [7:0] rxq[$];
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk);
      line_out = f[i];
      repeat (DIV - 1) @(negedge core_clk);
    end
  endtask
  // Bad stop bit drops the byte, so the bench then times out
  initial begin : rx_loop
    logic [7:0] v;
    forever begin
      @(negedge line_in);
      repeat (DIV / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge core_clk);
        v[i] = line_in;
      end
      repeat (DIV) @(posedge core_clk);
      if (line_in === 1'b1) rxq.push_back(v);
    end
  end
endmodule
`default_nettype wire

// [hw/cpf_flow.sv]
`timescale 1ns/1ns
`default_nettype none
module cpf_flow
  import cpf_pkg::*;
#(
  parameter int unsigned        DIV     = BAUD_DIV,
  // Identification text, value arbitrary
  parameter logic [8*ID_LEN-1:0] ID_TEXT = "CRD 0.1\r"
) (
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          ser_rx,
  output logic               ser_tx,
  output cpf_card_req_t      card_req,
  output cpf_byte_t          card_tx,
  input  wire cpf_byte_t     card_rx,
  input  wire cpf_card_rsp_t card_rsp,
  input  wire logic          card_present,
  output cpf_phase_t         phase
);

  typedef enum logic [3:0] {
    S_BANNER  = 4'h0,
    S_LEAD    = 4'h1,
    S_SUB     = 4'h2,
    S_LEN     = 4'h3,
    S_APDU    = 4'h4,
    S_CARD    = 4'h5,
    S_GONE    = 4'h6,
    S_ST      = 4'h7,
    S_LEN_OUT = 4'h8,
    S_DATA    = 4'h9
  } cpf_state_t;

  cpf_state_t state;
  logic       tx_go;
  logic [7:0] tx_byte;
  logic       tx_idle;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic [7:0] sub;
  logic       is_long;
  logic       bad;
  logic [7:0] apdu_left;
  logic [7:0] status;
  logic [7:0] resp_len;
  logic [7:0] idx;
  logic [7:0] resp_mem [0:255];
  logic       can_send;

  // Blocks a second send before the serialiser has seen the first
  assign can_send = tx_idle && !tx_go;

  function automatic logic cmd_ok(input logic [7:0] s, input cpf_phase_t ph);
    case (s)
      SUB_POLL:  cmd_ok = (ph == PH_POLL) || (ph == PH_ACT);
      SUB_ACT:   cmd_ok = (ph == PH_ACT);
      SUB_XCH,
      SUB_CSEND,
      SUB_CRECV: cmd_ok = (ph == PH_XACT);
      SUB_REL:   cmd_ok = (ph == PH_ACT) || (ph == PH_XACT);
      default:   cmd_ok = 1'b0;
    endcase
  endfunction

  function automatic cpf_op_t op_of(input logic [7:0] s);
    case (s)
      SUB_POLL:  op_of = OP_POLL;
      SUB_ACT:   op_of = OP_ACT;
      SUB_XCH:   op_of = OP_XCH;
      SUB_CSEND: op_of = OP_CSEND;
      SUB_CRECV: op_of = OP_CRECV;
      SUB_REL:   op_of = OP_REL;
      default:   op_of = OP_POLL;
    endcase
  endfunction

  function automatic logic [7:0] stat_of(input cpf_res_t r);
    case (r)
      RES_OK:   stat_of = STAT_OK;
      RES_MORE: stat_of = STAT_MORE;
      default:  stat_of = STAT_FAIL;
    endcase
  endfunction

  cpf_uart #(
    .DIV (DIV)
  ) u_uart (
    .core_clk (core_clk),
    .nrst     (nrst),
    .rx_pin   (ser_rx),
    .tx_pin   (ser_tx),
    .tx_go    (tx_go),
    .tx_byte  (tx_byte),
    .tx_idle  (tx_idle),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte)
  );

  // Card answer bytes; excess beyond 255 is dropped
  always_ff @(posedge core_clk) begin
    if (state == S_CARD && card_rx.valid && resp_len != LEN_MAX) begin
      resp_mem[resp_len] <= card_rx.data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= S_BANNER;
      phase     <= PH_POLL;
      tx_go     <= 1'b0;
      tx_byte   <= 8'h00;
      sub       <= 8'h00;
      is_long   <= 1'b0;
      bad       <= 1'b0;
      apdu_left <= 8'h00;
      status    <= STAT_OK;
      resp_len  <= 8'h00;
      idx       <= 8'h00;
      card_req  <= '0;
      card_tx   <= '0;
    end else begin
      tx_go         <= 1'b0;
      card_req.go   <= 1'b0;
      card_tx.valid <= 1'b0;
      case (state)
        S_BANNER: begin
          if (can_send) begin
            tx_go   <= 1'b1;
            tx_byte <= ID_TEXT[8*(ID_LEN-1-int'(idx)) +: 8];
            if (idx == 8'(ID_LEN - 1)) begin
              idx   <= 8'h00;
              state <= S_LEAD;
            end else begin
              idx <= idx + 8'h01;
            end
          end
        end
        S_LEAD: begin
          if (rx_valid && rx_byte == CMD_LEAD) begin
            state <= S_SUB;
          end
        end
        S_SUB: begin
          if (rx_valid) begin
            sub      <= rx_byte;
            is_long  <= (rx_byte == SUB_XCH) || (rx_byte == SUB_CSEND)
                        || (rx_byte == SUB_CRECV);
            bad      <= !cmd_ok(rx_byte, phase);
            resp_len <= 8'h00;
            if (rx_byte == SUB_XCH || rx_byte == SUB_CSEND) begin
              state <= S_LEN;
            end else if (!cmd_ok(rx_byte, phase)) begin
              status <= STAT_FAIL;
              state  <= S_ST;
            end else begin
              card_req.go <= 1'b1;
              card_req.op <= op_of(rx_byte);
              if (rx_byte == SUB_REL) begin
                phase <= PH_DEACT;
              end
              state <= S_CARD;
            end
          end
        end
        S_LEN, S_APDU: begin
          if (rx_valid) begin
            if (state == S_APDU && !bad) begin
              card_tx.valid <= 1'b1;
              card_tx.data  <= rx_byte;
            end
            apdu_left <= (state == S_LEN) ? rx_byte : apdu_left - 8'h01;
            if ((state == S_LEN && rx_byte == 8'h00)
                || (state == S_APDU && apdu_left == 8'h01)) begin
              // Bad command still swallows its APDU to keep framing
              if (bad) begin
                status <= STAT_FAIL;
                state  <= S_ST;
              end else begin
                card_req.go <= 1'b1;
                card_req.op <= op_of(sub);
                state       <= S_CARD;
              end
            end else begin
              state <= S_APDU;
            end
          end
        end
        S_CARD: begin
          if (card_rx.valid && resp_len != LEN_MAX) begin
            resp_len <= resp_len + 8'h01;
          end
          if (card_rsp.done) begin
            status <= stat_of(card_rsp.res);
            state  <= S_ST;
            case (card_req.op)
              OP_POLL: begin
                phase <= (card_rsp.res == RES_OK) ? PH_ACT : PH_POLL;
              end
              OP_ACT: begin
                phase <= (card_rsp.res == RES_OK) ? PH_XACT : PH_POLL;
              end
              OP_REL: begin
                if (card_rsp.res == RES_OK) begin
                  state <= S_GONE;
                end else begin
                  phase <= PH_POLL;
                end
              end
              default: phase <= PH_XACT;
            endcase
          end
        end
        S_GONE: begin
          if (!card_present) begin
            phase <= PH_POLL;
            state <= S_ST;
          end
        end
        S_ST: begin
          if (can_send) begin
            tx_go   <= 1'b1;
            tx_byte <= status;
            idx     <= 8'h00;
            state   <= is_long ? S_LEN_OUT : S_LEAD;
          end
        end
        S_LEN_OUT: begin
          if (can_send) begin
            tx_go   <= 1'b1;
            tx_byte <= resp_len;
            state   <= (resp_len == 8'h00) ? S_LEAD : S_DATA;
          end
        end
        S_DATA: begin
          if (can_send) begin
            tx_go   <= 1'b1;
            tx_byte <= resp_mem[idx];
            if (idx == resp_len - 8'h01) begin
              idx   <= 8'h00;
              state <= S_LEAD;
            end else begin
              idx <= idx + 8'h01;
            end
          end
        end
        default: state <= S_LEAD;
      endcase
    end
  end
endmodule
`default_nettype wire

// [hw/cpf_pkg.sv]
// Operation
// - Session runs poll, activate, transact, release phases; good poll enters activate, good activate enters transact, release command enters release.
// - Poll scans for type A and B cards; failure status when none found.
// - Activate runs card activation; host follows success with data exchange.
// - Status byte: 00 success, 04 general failure, 80 more data pending.
// - Poll, activate and release replies are the status byte alone.
// - Data exchange carries a variable-length APDU forwarded to the activated card.
// - Exchange replies send status, length byte, then exactly that many data bytes.
// - Chained send forwards a segment, flagging that more segments follow.
// - Release runs deactivation; on success the reply is withheld until the card leaves the field, on failure it is sent at once.
// - Serial link runs 9600 baud, 8 data bits, no parity, 1 stop.
// - After reset an identification string is sent before commands are accepted.
package cpf_pkg;

  localparam int unsigned CLK_HZ    = 250_000_000;
  localparam int unsigned BAUD_RATE = 9600;
  localparam int unsigned BAUD_DIV  = CLK_HZ / BAUD_RATE;
  localparam int unsigned ID_LEN    = 8;

  localparam logic [7:0] CMD_LEAD  = 8'h70;
  localparam logic [7:0] SUB_POLL  = 8'h70;
  localparam logic [7:0] SUB_ACT   = 8'h61;
  localparam logic [7:0] SUB_XCH   = 8'h74;
  localparam logic [7:0] SUB_CSEND = 8'h63;
  localparam logic [7:0] SUB_CRECV = 8'h6D;
  localparam logic [7:0] SUB_REL   = 8'h64;

  localparam logic [7:0] STAT_OK   = 8'h00;
  localparam logic [7:0] STAT_FAIL = 8'h04;
  localparam logic [7:0] STAT_MORE = 8'h80;
  localparam logic [7:0] LEN_MAX   = 8'hFF;

  typedef enum logic [2:0] {
    OP_POLL  = 3'h0,
    OP_ACT   = 3'h1,
    OP_XCH   = 3'h2,
    OP_CSEND = 3'h3,
    OP_CRECV = 3'h4,
    OP_REL   = 3'h5
  } cpf_op_t;

  typedef enum logic [1:0] {
    RES_OK   = 2'h0,
    RES_FAIL = 2'h1,
    RES_MORE = 2'h2
  } cpf_res_t;

  typedef enum logic [1:0] {
    PH_POLL  = 2'h0,
    PH_ACT   = 2'h1,
    PH_XACT  = 2'h2,
    PH_DEACT = 2'h3
  } cpf_phase_t;

  typedef struct packed {
    logic    go;
    cpf_op_t op;
  } cpf_card_req_t;

  typedef struct packed {
    logic     done;
    cpf_res_t res;
  } cpf_card_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cpf_byte_t;

endpackage

// [hw/cpf_uart.sv]
`timescale 1ns/1ns
`default_nettype none
module cpf_uart #(
  parameter int unsigned DIV = 26041
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       rx_pin,
  output logic            tx_pin,
  input  wire logic       tx_go,
  input  wire logic [7:0] tx_byte,
  output logic            tx_idle,
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  localparam int unsigned CW = $clog2(DIV + 1);

  logic          rx_s1;
  logic          rx_s2;
  logic          rx_busy;
  logic [CW-1:0] rx_cnt;
  logic [3:0]    rx_bit;
  logic [7:0]    rx_sh;
  logic [CW-1:0] tx_cnt;
  logic [3:0]    tx_bit;
  logic [9:0]    tx_sh;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
    end
  end

  // Sample mid-bit: half a bit after the start edge, then whole bits
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_busy  <= 1'b0;
      rx_cnt   <= '0;
      rx_bit   <= 4'h0;
      rx_sh    <= 8'h00;
      rx_valid <= 1'b0;
      rx_byte  <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy) begin
        if (!rx_s2) begin
          rx_busy <= 1'b1;
          rx_cnt  <= CW'(DIV / 2);
          rx_bit  <= 4'h0;
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt <= CW'(DIV - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          if (rx_s2) begin
            rx_busy <= 1'b0; // Glitch, not a start bit
          end
        end else if (rx_bit < 4'h9) begin
          rx_sh <= {rx_s2, rx_sh[7:1]};
        end else begin
          rx_busy  <= 1'b0;
          rx_valid <= rx_s2; // Framing error drops the byte
          rx_byte  <= rx_sh;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_idle <= 1'b1;
      tx_pin  <= 1'b1;
      tx_cnt  <= '0;
      tx_bit  <= 4'h0;
      tx_sh   <= 10'h3FF;
    end else if (tx_idle) begin
      if (tx_go) begin
        tx_idle <= 1'b0;
        tx_sh   <= {1'b1, tx_byte, 1'b0};
        tx_pin  <= 1'b0;
        tx_cnt  <= CW'(DIV - 1);
        tx_bit  <= 4'h0;
      end
    end else if (tx_cnt != '0) begin
      tx_cnt <= tx_cnt - 1'b1;
    end else begin
      tx_cnt <= CW'(DIV - 1);
      tx_bit <= tx_bit + 4'h1;
      tx_sh  <= {1'b1, tx_sh[9:1]};
      tx_pin <= tx_sh[1];
      if (tx_bit == 4'h9) begin
        tx_idle <= 1'b1;
        tx_pin  <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
